// *** common/qad_pkg.sv ***
// Purpose: Shared constants, types and helpers of the quadrature axis decoder.
// Assumes: One 50 MHz clock, AXI4-Lite register access, 8-bit byte address.
// Notes:   Offsets are byte addresses; each register is one aligned word.
package qad_pkg;

  localparam int unsigned QAD_AXES   = 3;
  localparam int unsigned QAD_TIMERS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets.
  localparam logic [7:0] QAD_OFS_CTRL   = 8'h00;
  localparam logic [7:0] QAD_OFS_DRIVE  = 8'h04;
  localparam logic [7:0] QAD_OFS_STATUS = 8'h08;
  localparam logic [7:0] QAD_OFS_TIMER  = 8'h10; // Two words per timer.
  localparam logic [7:0] QAD_OFS_COUNT  = 8'h30; // One word per axis.
  localparam logic [7:0] QAD_OFS_END    = 8'h3c;

  // Field positions.
  localparam int unsigned QAD_CTRL_RUN_BIT    = 0;
  localparam int unsigned QAD_CTRL_SEL_LSB    = 1;
  localparam int unsigned QAD_STAT_GLITCH_LSB = 10;

  // Reset values.
  localparam logic [6:0]  QAD_CTRL_RESET   = 7'h00;
  localparam logic [15:0] QAD_DRIVE_RESET  = 16'h0000;
  localparam logic [15:0] QAD_PERIOD_RESET = 16'hffff;
  localparam logic [15:0] QAD_EDGE_RESET   = 16'h0000;

  // AXI response codes.
  localparam logic [1:0] QAD_RESP_OKAY   = 2'b00;
  localparam logic [1:0] QAD_RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Off condition of a drive output; code 2'b11 behaves as high impedance.
  typedef enum logic [1:0]
  {
    QAD_OFF_FLOAT = 2'b00,
    QAD_OFF_LOW   = 2'b01,
    QAD_OFF_HIGH  = 2'b10
  } qad_off_mode_t;

  // One nibble of the drive configuration register.
  typedef struct packed {
    qad_off_mode_t off_mode;
    logic          active_low;
    logic          enable;
  } qad_drive_cfg_t;

  // Settings of one PWM timer, as two register words.
  typedef struct packed {
    logic [15:0] off_time;
    logic [15:0] on_time;
    logic [15:0] sample_time;
    logic [15:0] period;
  } qad_timer_cfg_t;

  typedef enum logic [2:0]
  {
    QAD_REG_NONE,
    QAD_REG_CTRL,
    QAD_REG_DRIVE,
    QAD_REG_STATUS,
    QAD_REG_EDGES,
    QAD_REG_PACE,
    QAD_REG_COUNT
  } qad_reg_kind_t;

  typedef struct packed {
    qad_reg_kind_t kind;
    logic [1:0]    idx;
  } qad_sel_t;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by the read and the write path.
  function automatic qad_sel_t qad_decode(input logic [7:0] addr);
    qad_sel_t   s;
    logic [7:0] rel;
    rel    = addr - QAD_OFS_TIMER;
    s.kind = QAD_REG_NONE;
    s.idx  = rel[4:3];
    if (addr[7:2] == QAD_OFS_CTRL[7:2])
      s.kind = QAD_REG_CTRL;
    else if (addr[7:2] == QAD_OFS_DRIVE[7:2])
      s.kind = QAD_REG_DRIVE;
    else if (addr[7:2] == QAD_OFS_STATUS[7:2])
      s.kind = QAD_REG_STATUS;
    else if (addr >= QAD_OFS_TIMER && addr < QAD_OFS_COUNT)
      s.kind = rel[2] ? QAD_REG_PACE : QAD_REG_EDGES;
    else if (addr >= QAD_OFS_COUNT && addr < QAD_OFS_END)
    begin
      s.kind = QAD_REG_COUNT;
      s.idx  = addr[3:2];
    end
    return s;
  endfunction

  // Byte-lane merge of a write into the old register word.
  function automatic logic [31:0] qad_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

endpackage

// *** src/qad_pwm_timer.sv ***
// Purpose: One 16-bit PWM timer with an on window and a sample strobe.
// Assumes: Settings may change at any time; new values act next cycle.
// Notes:   Cycle length is period plus one clocks.
`timescale 1ns/1ns
module qad_pwm_timer
  import qad_pkg::*;
(
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           run,
  input  wire qad_timer_cfg_t cfg,
  output logic                drive_on,
  output logic                sample_stb
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        on_reg;
  logic        on_next;
  logic        stb_reg;
  logic        stb_next;
  wire         at_end     = cnt_reg >= cfg.period;
  wire         wrap       = cfg.off_time < cfg.on_time;
  wire         after_on   = cnt_reg >= cfg.on_time;
  wire         before_off = cnt_reg < cfg.off_time;

  ////////////////////////////////////////////////////////////////////////////
  // Free count per timer, cleared while stopped so restarts are repeatable.
  assign cnt_next = (!run || at_end) ? 16'h0000 : cnt_reg + 16'h0001;
  // A window with off before on wraps round the period end.
  assign on_next  = run && (wrap ? (after_on || before_off)
                                 : (after_on && before_off));
  assign stb_next = run && (cnt_reg == cfg.sample_time);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= 16'h0000;
      on_reg  <= 1'b0;
      stb_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      on_reg  <= on_next;
      stb_reg <= stb_next;
    end
  end

  assign drive_on   = on_reg;
  assign sample_stb = stb_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  timer_wrap_a: assert property (
    run && at_end |=> cnt_reg == 16'h0000)
    else $error("timer did not wrap at its period");

  switch_on_a: assert property (
    run && !wrap && cnt_reg == cfg.on_time && before_off |=> drive_on)
    else $error("drive window did not open at on time");

  switch_off_a: assert property (
    run && !wrap && cnt_reg == cfg.off_time |=> !drive_on)
    else $error("drive window did not close at off time");

  sample_time_a: assert property (
    sample_stb |-> $past(run) && $past(cnt_reg) == $past(cfg.sample_time))
    else $error("sample strobe away from its programmed time");

endmodule // qad_pwm_timer

// *** src/qad_quad_axis.sv ***
// Purpose: Sample one quadrature pair and keep its signed displacement.
// Assumes: Phase inputs are synchronous to aclk.
// Notes:   Forward is phase a leading phase b; double changes count nothing.
`timescale 1ns/1ns
module qad_quad_axis
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sample_stb,
  input  wire logic        phase_a,
  input  wire logic        phase_b,
  input  wire logic        clear,
  output logic [15:0]      count,
  output logic [1:0]       phases,
  output logic             glitch
);

  logic [1:0]  state_reg;
  logic        primed_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        glitch_reg;
  wire  [1:0]  now  = {phase_a, phase_b};
  // The first sample after reset only loads, so no false step is counted.
  wire         fwd  = sample_stb && primed_reg &&
                      now == {~state_reg[0], state_reg[1]};
  wire         rev  = sample_stb && primed_reg &&
                      now == {state_reg[0], ~state_reg[1]};
  wire         dbl  = sample_stb && primed_reg && now == ~state_reg;
  wire  [15:0] base = clear ? 16'h0000 : count_reg;

  ////////////////////////////////////////////////////////////////////////////
  // A clear in the same cycle as a step keeps the step.
  assign count_next = fwd ? base + 16'h0001 :
                      rev ? base - 16'h0001 : base;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg  <= 2'b00;
      primed_reg <= 1'b0;
      count_reg  <= 16'h0000;
      glitch_reg <= 1'b0;
    end
    else
    begin
      state_reg  <= sample_stb ? now : state_reg;
      primed_reg <= primed_reg | sample_stb;
      count_reg  <= count_next;
      glitch_reg <= dbl;
    end
  end

  assign count  = count_reg;
  assign phases = state_reg;
  assign glitch = glitch_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence fwd_step_s;
    sample_stb && primed_reg && !clear && state_reg == 2'b00 && now == 2'b10;
  endsequence

  sequence rev_step_s;
    sample_stb && primed_reg && !clear && state_reg == 2'b00 && now == 2'b01;
  endsequence

  sample_load_a: assert property (
    sample_stb |=> phases == $past(now))
    else $error("sampled phases not stored");

  step_up_a: assert property (
    fwd_step_s |=> count == $past(count) + 16'h0001)
    else $error("forward step not counted");

  step_down_a: assert property (
    rev_step_s |=> count == $past(count) - 16'h0001)
    else $error("reverse step not counted");

  hold_count_a: assert property (
    !sample_stb && !clear |=> $stable(count))
    else $error("count moved without a sample");

endmodule // qad_quad_axis

// *** src/qad_decoder_top.sv ***
// Purpose: Three-axis quadrature decoder with four timed drive outputs.
// Assumes: AXI4-Lite master keeps at most one write and one read open.
// Notes:   Timers 0..2 pace the three axes; timer 3 only shapes output 3.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
module qad_decoder_top
  import qad_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  horizontal_phase_a,
  input  wire logic [1:0]  horizontal_phase_b,
  input  wire logic [1:0]  vertical_phase_a,
  input  wire logic [1:0]  vertical_phase_b,
  input  wire logic [1:0]  wheel_phase_a,
  input  wire logic [1:0]  wheel_phase_b,
  output logic [3:0]       high_current_drive_output,
  output logic [3:0]       high_current_drive_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state.
  logic           awready_reg;
  logic           wready_reg;
  logic           aw_full_reg;
  logic           w_full_reg;
  logic [7:0]     awaddr_reg;
  logic [31:0]    wdata_reg;
  logic [3:0]     wstrb_reg;
  logic           bvalid_reg;
  logic [1:0]     bresp_reg;
  logic           arready_reg;
  logic           rvalid_reg;
  logic [31:0]    rdata_reg;
  logic [1:0]     rresp_reg;
  logic [31:0]    rd_word;

  // Block registers and state.
  logic [6:0]     ctrl_reg;
  logic [15:0]    drive_reg;
  logic [2:0]     glitch_reg;
  qad_timer_cfg_t timer_reg [QAD_TIMERS];
  logic [3:0]     hc_out_reg;
  logic [3:0]     hc_oe_reg;
  logic [3:0]     timer_on;
  logic [3:0]     timer_stb;
  logic [1:0]     pin_a [QAD_AXES];
  logic [1:0]     pin_b [QAD_AXES];
  logic [15:0]    axis_count [QAD_AXES];
  logic [1:0]     axis_phase [QAD_AXES];
  logic [2:0]     axis_glitch;
  logic [2:0]     count_hit;
  logic [3:0]     out_on;
  logic [3:0]     out_level;
  logic [3:0]     out_oe;
  qad_drive_cfg_t drive_cfg [QAD_TIMERS];

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data are held apart and joined once both are in.
  wire        aw_take  = s_axi_awvalid && awready_reg;
  wire        w_take   = s_axi_wvalid && wready_reg;
  wire        wr_do    = aw_full_reg && w_full_reg && !bvalid_reg;
  wire        aw_full_next = aw_take || (aw_full_reg && !wr_do);
  wire        w_full_next  = w_take || (w_full_reg && !wr_do);
  wire        bvalid_next  = wr_do || (bvalid_reg && !s_axi_bready);
  wire qad_sel_t wr_sel    = qad_decode(awaddr_reg);
  wire        wr_ctrl  = wr_do && wr_sel.kind == QAD_REG_CTRL;
  wire        wr_drive = wr_do && wr_sel.kind == QAD_REG_DRIVE;
  wire        wr_stat  = wr_do && wr_sel.kind == QAD_REG_STATUS;
  wire [31:0] ctrl_new = qad_merge({25'h0, ctrl_reg}, wdata_reg, wstrb_reg);
  wire [31:0] drv_new  = qad_merge({16'h0, drive_reg}, wdata_reg, wstrb_reg);
  // Glitch flags clear by writing one; only a fully enabled byte counts.
  wire [2:0]  glitch_clr = wr_stat && wstrb_reg[1] ?
                           wdata_reg[QAD_STAT_GLITCH_LSB +: 3] : 3'b000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= QAD_RESP_OKAY;
    end
    else
    begin
      awready_reg <= !aw_full_next && !bvalid_next;
      wready_reg  <= !w_full_next && !bvalid_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      bvalid_reg  <= bvalid_next;
      if (wr_do)
        bresp_reg <= wr_sel.kind == QAD_REG_NONE ? QAD_RESP_SLVERR
                                                 : QAD_RESP_OKAY;
    end
  end

  // Payload latches carry no control meaning, so they need no reset.
  always_ff @(posedge aclk)
  begin
    if (aw_take)
      awaddr_reg <= s_axi_awaddr;
    if (w_take)
    begin
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
  end

  // Control, drive configuration and sticky glitch flags; a new glitch
  // beats a clear in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg   <= QAD_CTRL_RESET;
      drive_reg  <= QAD_DRIVE_RESET;
      glitch_reg <= 3'b000;
    end
    else
    begin
      ctrl_reg   <= wr_ctrl ? ctrl_new[6:0] : ctrl_reg;
      drive_reg  <= wr_drive ? drv_new[15:0] : drive_reg;
      glitch_reg <= axis_glitch | (glitch_reg & ~glitch_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one read in flight, data latched at the address handshake.
  wire           ar_take     = s_axi_arvalid && arready_reg;
  wire           rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);
  wire qad_sel_t rd_sel      = qad_decode(s_axi_araddr);
  wire [31:0]    status_word = {19'h0, glitch_reg,
                                axis_phase[2], axis_phase[1], axis_phase[0],
                                hc_out_reg};

  always_comb
  begin
    case (rd_sel.kind)
      QAD_REG_CTRL:   rd_word = {25'h0, ctrl_reg};
      QAD_REG_DRIVE:  rd_word = {16'h0, drive_reg};
      QAD_REG_STATUS: rd_word = status_word;
      QAD_REG_EDGES:  rd_word = timer_reg[rd_sel.idx][63:32];
      QAD_REG_PACE:   rd_word = timer_reg[rd_sel.idx][31:0];
      QAD_REG_COUNT:  rd_word = {16'h0, axis_count[rd_sel.idx]};
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= QAD_RESP_OKAY;
    end
    else
    begin
      arready_reg <= !rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take)
      begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_sel.kind == QAD_REG_NONE ? QAD_RESP_SLVERR
                                                 : QAD_RESP_OKAY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timers and drive outputs. Stopping the block parks every output in
  // its off condition; an output set to QAD_OFF_HIGH stays driven high while idle.
  wire run = ctrl_reg[QAD_CTRL_RUN_BIT];

  for (genvar k = 0; k < QAD_TIMERS; k++)
  begin : g_timer
    wire        hit_e = wr_do && wr_sel.kind == QAD_REG_EDGES &&
                        wr_sel.idx == 2'(k);
    wire        hit_p = wr_do && wr_sel.kind == QAD_REG_PACE &&
                        wr_sel.idx == 2'(k);
    wire [31:0] new_e = qad_merge(timer_reg[k][63:32], wdata_reg, wstrb_reg);
    wire [31:0] new_p = qad_merge(timer_reg[k][31:0], wdata_reg, wstrb_reg);

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        timer_reg[k] <= {QAD_EDGE_RESET, QAD_EDGE_RESET,
                         QAD_EDGE_RESET, QAD_PERIOD_RESET};
      else if (hit_e)
        timer_reg[k][63:32] <= new_e;
      else if (hit_p)
        timer_reg[k][31:0] <= new_p;
    end

    qad_pwm_timer u_timer (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .run        (run),
      .cfg        (timer_reg[k]),
      .drive_on   (timer_on[k]),
      .sample_stb (timer_stb[k])
    );

    assign drive_cfg[k] = qad_drive_cfg_t'(drive_reg[4*k +: 4]);
    assign out_on[k]    = run && drive_cfg[k].enable && timer_on[k];
    assign out_level[k] = out_on[k] ? !drive_cfg[k].active_low
                        : drive_cfg[k].off_mode == QAD_OFF_HIGH;
    assign out_oe[k]    = out_on[k] || drive_cfg[k].off_mode == QAD_OFF_LOW
                        || drive_cfg[k].off_mode == QAD_OFF_HIGH;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hc_out_reg <= 4'h0;
      hc_oe_reg  <= 4'h0;
    end
    else
    begin
      hc_out_reg <= out_level;
      hc_oe_reg  <= out_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Axes: pin choice per phase, sampled on the strobe of the axis timer.
  assign pin_a[0] = horizontal_phase_a;
  assign pin_b[0] = horizontal_phase_b;
  assign pin_a[1] = vertical_phase_a;
  assign pin_b[1] = vertical_phase_b;
  assign pin_a[2] = wheel_phase_a;
  assign pin_b[2] = wheel_phase_b;

  for (genvar a = 0; a < QAD_AXES; a++)
  begin : g_axis
    wire sel_a = ctrl_reg[QAD_CTRL_SEL_LSB + 2*a];
    wire sel_b = ctrl_reg[QAD_CTRL_SEL_LSB + 2*a + 1];
    // Writing a count register clears it.
    assign count_hit[a] = wr_do && wr_sel.kind == QAD_REG_COUNT &&
                          wr_sel.idx == 2'(a);

    qad_quad_axis u_axis (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .sample_stb (timer_stb[a]),
      .phase_a    (pin_a[a][sel_a]),
      .phase_b    (pin_b[a][sel_b]),
      .clear      (count_hit[a]),
      .count      (axis_count[a]),
      .phases     (axis_phase[a]),
      .glitch     (axis_glitch[a])
    );
  end

  assign s_axi_awready             = awready_reg;
  assign s_axi_wready              = wready_reg;
  assign s_axi_bvalid              = bvalid_reg;
  assign s_axi_bresp               = bresp_reg;
  assign s_axi_arready             = arready_reg;
  assign s_axi_rvalid              = rvalid_reg;
  assign s_axi_rdata               = rdata_reg;
  assign s_axi_rresp               = rresp_reg;
  assign high_current_drive_output = hc_out_reg;
  assign high_current_drive_oe     = hc_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  drive_active_a: assert property (
    out_on[1] |=> high_current_drive_oe[1] &&
      high_current_drive_output[1] == !$past(drive_cfg[1].active_low))
    else $error("active drive level wrong for output 1");

  off_float_a: assert property (
    !out_on[1] && drive_cfg[1].off_mode == QAD_OFF_FLOAT
      |=> !high_current_drive_oe[1])
    else $error("floating off output 1 still driven");

  off_driven_a: assert property (
    !out_on[2] && drive_cfg[2].off_mode == QAD_OFF_HIGH
      |=> high_current_drive_oe[2] && high_current_drive_output[2])
    else $error("off output 2 not driven high");

  stopped_quiet_a: assert property (
    !run [*2] |-> !high_current_drive_oe[3] ||
      $past(drive_cfg[3].off_mode) != QAD_OFF_FLOAT)
    else $error("output 3 driven while stopped and floating");

  pin_route_a: assert property (
    timer_stb[0] |=> axis_phase[0][1] ==
      $past(horizontal_phase_a[ctrl_reg[QAD_CTRL_SEL_LSB]]))
    else $error("horizontal phase a taken from wrong pin");

  axis_apart_a: assert property (
    !timer_stb[1] |=> $stable(axis_phase[1]))
    else $error("vertical axis moved without its own strobe");

  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before acceptance");

endmodule // qad_decoder_top

// *** bench/qad_sensor_model.sv ***
// Purpose: Model of the optical sensors that feed the three phase pairs.
// Assumes: Step pulses come slower than the sampling of each axis.
// Notes:   The unselected pin toggles every cycle, so a wrong pick shows.
`timescale 1ns/1ns
module qad_sensor_model
(
  input  wire logic       aclk,
  input  wire logic [2:0] step,
  input  wire logic [2:0] back,
  input  wire logic [5:0] sel,
  output logic      [1:0] pin [6]
);
  logic [1:0] pos [3] = '{3{2'b00}};
  logic       tg      = 1'b0;

  // Each pulse moves the gray position one state forward or back.
  always @(posedge aclk)
  begin
    tg <= ~tg;
    for (int i = 0; i < 3; i++)
      if (step[i])
        pos[i] <= back[i] ? pos[i] - 2'd1 : pos[i] + 2'd1;
  end

  // Phase a leads b going forward; the spare pin carries noise.
  always_comb
  begin
    logic p;
    p = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      p = i[0] ? pos[i/2][1] : ^pos[i/2];
      pin[i] = sel[i] ? {p, tg} : {tg, p};
    end
  end
endmodule // qad_sensor_model

// *** bench/quadrature_axis_decoder_tb_top.sv ***
// Purpose: Register level test of the three axis decoder.
// Assumes: Both handshakes of a write are offered together.
// Notes:   Short timer periods keep the run brief.
`timescale 1ns/1ns
module quadrature_axis_decoder_tb_top;
  import qad_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0;
  logic [1:0] bresp, rresp, r;
  logic [1:0] pin [6];
  logic [2:0] step = 3'h0, back = 3'h0;
  logic [3:0] hc, oe;
  int fail_count = 0, comparisons = 0, n3, o3, o0, o1, l1;

  always #10 aclk = ~aclk;

  qad_decoder_top qad_decoder_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .horizontal_phase_a(pin[0]), .horizontal_phase_b(pin[1]),
    .vertical_phase_a(pin[2]), .vertical_phase_b(pin[3]),
    .wheel_phase_a(pin[4]), .wheel_phase_b(pin[5]),
    .high_current_drive_output(hc), .high_current_drive_oe(oe));

  qad_sensor_model qad_sensor_model_inst (.aclk(aclk), .step(step),
    .back(back), .sel(6'b110011), .pin(pin));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write with address and data offered together, each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Each channel stays offered until the edge at which its ready is seen.
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata; r = rresp;
    rready <= 0;
  endtask

  // One step pulse, then time for at least two samples of every axis.
  task automatic mv(input logic [2:0] s, input logic [2:0] b);
    @(posedge aclk);
    step <= s; back <= b;
    @(posedge aclk);
    step <= 3'h0;
    repeat (10) @(posedge aclk);
  endtask

  task automatic end_sim;
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog against a handshake that never completes.
  initial
  begin
    #(20 * 5000);
    fail_count++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h14); chk(d, 32'h0000ffff);
    rd(8'h30); chk(d, 32'h0);
    chk(oe, 4'h0);
    rd(8'h3c);
    chk(d, 32'h0);
    chk(r, 2'b10);
    wr(8'h3c, 32'h1); chk(r, 2'b10);
    for (int k = 0; k < 3; k++)
      wr(8'h14 + 8'(8 * k), 32'h3 | (k << 16));
    wr(8'h18, 32'h00030001);
    wr(8'h28, 32'h00030001);
    wr(8'h2c, 32'h3);
    wr(8'h04, 32'h0000b850);
    wr(8'h00, 32'h67);
    repeat (12) @(posedge aclk);
    mv(3'b111, 3'b010);
    mv(3'b011, 3'b010);
    mv(3'b001, 3'b000);
    rd(8'h30); chk(d, 32'h3);
    rd(8'h34); chk(d, 32'h0000fffe);
    rd(8'h38); chk(d, 32'h1);
    rd(8'h00);
    chk(d, 32'h67);
    n3 = 0;
    o3 = 0;
    o0 = 0;
    o1 = 0;
    l1 = 0;
    repeat (8)
    begin
      @(posedge aclk);
      n3 += hc[3]; o3 += oe[3]; o0 += oe[0]; o1 += oe[1]; l1 += hc[1];
    end
    chk(n3, 4);
    chk(o3, 8);
    chk(o0, 0);
    chk(o1, 8);
    chk(l1, 4);
    chk({hc[2], oe[2]}, 2'b11);
    wr(8'h34, 32'h0); rd(8'h34); chk(d, 32'h0);
    end_sim();
  end
endmodule // quadrature_axis_decoder_tb_top
